// File: rtl/gpx_ports.sv
// Three 8-bit GPIO ports with four external interrupt inputs.
`timescale 1ns/1ps
`default_nettype none
module gpx_ports
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Internal data bus.
    input wire gpx_pkg::gpx_req_t req,
    output logic [7:0] rdata,
    // Pads, sampled levels after the Schmitt input stage.
    input wire logic [7:0] p1_in,
    input wire logic [7:0] p2_in,
    input wire logic [7:0] p3_in,
    output gpx_pkg::gpx_pad_t p1_pad,
    output gpx_pkg::gpx_pad_t p2_pad,
    output gpx_pkg::gpx_pad_t p3_pad,
    // Analog path enables for port 1 pins.
    output logic [7:0] analog_en,
    // Interrupt request to the core.
    output logic irq
);
    logic [7:0] p1_dat_q, p1_dat_d, p1_dir_q, p1_dir_d, p1_pu_q, p1_pu_d, ana_q, ana_d;
    logic [7:0] p2_dat_q, p2_dat_d, p2_dir_q, p2_dir_d, p2_pu_q, p2_pu_d, p2_mode_q, p2_mode_d;
    logic [7:0] p3_dat_q, p3_dat_d, p3_dir_q, p3_dir_d, p3_pu_q, p3_pu_d, p3_mode_q, p3_mode_d;
    logic [7:0] od_q, od_d, iflag_q, iflag_d, ien_q, ien_d, rdata_d, rdata_q;
    logic [7:0] s1a_q, s1b_q, s2a_q, s2b_q, s3a_q, s3b_q;
    logic [3:0] ext_pin, ext_trig, ext_lvl;
    logic [7:0] ext_mode;
    logic irq_d, irq_q;
    logic [7:0] analog_en_d;
    gpx_pkg::gpx_pad_t p1_d, p2_d, p3_d, p1_q, p2_q, p3_q;

    // External interrupt lines: port 2 bits 0,1 and port 3 bits 0,1.
    assign ext_pin = {p3_in[1], p3_in[0], p2_in[1], p2_in[0]};
    assign ext_mode = {p3_mode_q[3:0], p2_mode_q[3:0]};

    // One detector per interrupt line, each with its own synchroniser.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ext
            gpx_edge u_edge
            (
                .clk(clk),
                .nrst(nrst),
                .pin(ext_pin[g]),
                .mode(ext_mode[2*g+1:2*g]),
                .level(ext_lvl[g]),
                .trig(ext_trig[g])
            );
        end
    endgenerate

    // Register writes; each register holds until the next write to it, except flag bits 3:0, which triggers also set.
    always_comb
    begin
        p1_dat_d = p1_dat_q;
        p1_dir_d = p1_dir_q;
        p1_pu_d = p1_pu_q;
        ana_d = ana_q;
        p2_dat_d = p2_dat_q;
        p2_dir_d = p2_dir_q;
        p2_pu_d = p2_pu_q;
        p2_mode_d = p2_mode_q;
        p3_dat_d = p3_dat_q;
        p3_dir_d = p3_dir_q;
        p3_pu_d = p3_pu_q;
        p3_mode_d = p3_mode_q;
        od_d = od_q;
        ien_d = ien_q;
        iflag_d = iflag_q;
        if (req.wr)
        begin
            if (req.addr == gpx_pkg::ADDR_P1_DATA)
                p1_dat_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P1_DIR)
                p1_dir_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P1_PU)
                p1_pu_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P1_ANA)
                ana_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P2_DATA)
                p2_dat_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P2_DIR)
                p2_dir_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P2_PU)
                p2_pu_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P2_MODE)
                p2_mode_d = req.wdata & gpx_pkg::MASK_MODE;
            else if (req.addr == gpx_pkg::ADDR_P3_DATA)
                p3_dat_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P3_DIR)
                p3_dir_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P3_PU)
                p3_pu_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_P3_MODE)
                p3_mode_d = req.wdata & gpx_pkg::MASK_MODE;
            else if (req.addr == gpx_pkg::ADDR_P2_OD)
                od_d = req.wdata & gpx_pkg::MASK_OD;
            else if (req.addr == gpx_pkg::ADDR_IRQ_EN)
                ien_d = req.wdata;
            else if (req.addr == gpx_pkg::ADDR_IRQ_FLAG)
                iflag_d = req.wdata;
        end
        // A trigger in the same cycle as a flag write still sets the flag.
        iflag_d[3:0] = iflag_d[3:0] | ext_trig;
    end

    // Pad drive. Open drain only drives low; a one releases the pin.
    always_comb
    begin
        p1_d.out = p1_dat_q;
        p1_d.oe = p1_dir_q;
        p1_d.pu = p1_pu_q;
        p2_d.out = p2_dat_q;
        p2_d.oe = p2_dir_q;
        p2_d.pu = p2_pu_q;
        p2_d.out[4:3] = p2_dat_q[4:3] & ~od_q[4:3];
        p2_d.oe[4:3] = p2_dir_q[4:3] & ~(od_q[4:3] & p2_dat_q[4:3]);
        p3_d.out = p3_dat_q;
        p3_d.oe = p3_dir_q;
        p3_d.pu = p3_pu_q;
        irq_d = ien_q[gpx_pkg::GIE_BIT] & (|(iflag_q[3:0] & ien_q[3:0]));
        analog_en_d = ~ana_q & gpx_pkg::MASK_ANA;
    end

    // Input synchronisers for the plain port reads.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1a_q <= gpx_pkg::RST_ZERO;
            s1b_q <= gpx_pkg::RST_ZERO;
            s2a_q <= gpx_pkg::RST_ZERO;
            s2b_q <= gpx_pkg::RST_ZERO;
            s3a_q <= gpx_pkg::RST_ZERO;
            s3b_q <= gpx_pkg::RST_ZERO;
        end
        else
        begin
            s1a_q <= p1_in;
            s1b_q <= s1a_q;
            s2a_q <= p2_in;
            s2b_q <= s2a_q;
            s3a_q <= p3_in;
            s3b_q <= s3a_q;
        end
    end

    // Read mux. Port 1 digital path is gated by the analog disable bit, except bits 6 and 7.
    always_comb
    begin
        rdata_d = gpx_pkg::RST_ZERO;
        if (req.rd)
        begin
            if (req.addr == gpx_pkg::ADDR_P1_DATA)
                rdata_d = s1b_q & (ana_q | ~gpx_pkg::MASK_ANA);
            else if (req.addr == gpx_pkg::ADDR_P1_DIR)
                rdata_d = p1_dir_q;
            else if (req.addr == gpx_pkg::ADDR_P1_PU)
                rdata_d = p1_pu_q;
            else if (req.addr == gpx_pkg::ADDR_P1_ANA)
                rdata_d = ana_q;
            else if (req.addr == gpx_pkg::ADDR_P2_DATA)
                rdata_d = {s2b_q[7:2], ext_lvl[1:0]};
            else if (req.addr == gpx_pkg::ADDR_P2_DIR)
                rdata_d = p2_dir_q;
            else if (req.addr == gpx_pkg::ADDR_P2_PU)
                rdata_d = p2_pu_q;
            else if (req.addr == gpx_pkg::ADDR_P2_MODE)
                rdata_d = p2_mode_q;
            else if (req.addr == gpx_pkg::ADDR_P3_DATA)
                rdata_d = {s3b_q[7:2], ext_lvl[3:2]};
            else if (req.addr == gpx_pkg::ADDR_P3_DIR)
                rdata_d = p3_dir_q;
            else if (req.addr == gpx_pkg::ADDR_P3_PU)
                rdata_d = p3_pu_q;
            else if (req.addr == gpx_pkg::ADDR_P3_MODE)
                rdata_d = p3_mode_q;
            else if (req.addr == gpx_pkg::ADDR_P2_OD)
                rdata_d = od_q;
            else if (req.addr == gpx_pkg::ADDR_IRQ_EN)
                rdata_d = ien_q;
            else if (req.addr == gpx_pkg::ADDR_IRQ_FLAG)
                rdata_d = iflag_q;
        end
    end

    // State registers; data latches reset to zero since their power-up value is undefined.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            p1_dat_q <= gpx_pkg::RST_ZERO;
            p1_dir_q <= gpx_pkg::RST_ZERO;
            p1_pu_q <= gpx_pkg::RST_ZERO;
            ana_q <= gpx_pkg::RST_ZERO;
            p2_dat_q <= gpx_pkg::RST_ZERO;
            p2_dir_q <= gpx_pkg::RST_ZERO;
            p2_pu_q <= gpx_pkg::RST_ZERO;
            p2_mode_q <= gpx_pkg::RST_ZERO;
            p3_dat_q <= gpx_pkg::RST_ZERO;
            p3_dir_q <= gpx_pkg::RST_ZERO;
            p3_pu_q <= gpx_pkg::RST_ZERO;
            p3_mode_q <= gpx_pkg::RST_ZERO;
            od_q <= gpx_pkg::RST_OD;
            ien_q <= gpx_pkg::RST_ZERO;
            iflag_q <= gpx_pkg::RST_ZERO;
            rdata_q <= gpx_pkg::RST_ZERO;
            p1_q <= '0;
            p2_q <= '0;
            p3_q <= '0;
            analog_en <= gpx_pkg::RST_ZERO;
            irq_q <= 1'b0;
        end
        else
        begin
            p1_dat_q <= p1_dat_d;
            p1_dir_q <= p1_dir_d;
            p1_pu_q <= p1_pu_d;
            ana_q <= ana_d;
            p2_dat_q <= p2_dat_d;
            p2_dir_q <= p2_dir_d;
            p2_pu_q <= p2_pu_d;
            p2_mode_q <= p2_mode_d;
            p3_dat_q <= p3_dat_d;
            p3_dir_q <= p3_dir_d;
            p3_pu_q <= p3_pu_d;
            p3_mode_q <= p3_mode_d;
            od_q <= od_d;
            ien_q <= ien_d;
            iflag_q <= iflag_d;
            rdata_q <= rdata_d;
            p1_q <= p1_d;
            p2_q <= p2_d;
            p3_q <= p3_d;
            analog_en <= analog_en_d;
            irq_q <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign p1_pad = p1_q;
    assign p2_pad = p2_q;
    assign p3_pad = p3_q;
    assign irq = irq_q;

    // Checks.
    AST_P1_LATCH: assert property (@(posedge clk) disable iff (!nrst)
        req.wr && req.addr == gpx_pkg::ADDR_P1_DATA |-> ##2 p1_pad.out == $past(req.wdata, 2))
        else $error("port 1 output not latched");
    AST_P1_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !$past(req.wr) |-> $stable(p1_dat_q))
        else $error("port 1 latch changed without write");
    AST_OD_RESET: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> od_q[4:3] == 2'b11)
        else $error("open drain reset wrong");
    AST_OD_HIGH: assert property (@(posedge clk) disable iff (!nrst)
        od_q[3] && p2_dat_q[3] |=> !p2_pad.oe[3])
        else $error("open drain drove high");
    AST_P1_DIR: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> p1_pad.oe == $past(p1_dir_q))
        else $error("port 1 direction wrong");
    AST_ANA_GATE: assert property (@(posedge clk) disable iff (!nrst)
        req.rd && req.addr == gpx_pkg::ADDR_P1_DATA && !ana_q[0] |=> rdata[0] == 1'b0)
        else $error("analog pin leaked digital level");
    AST_HIGH_DIG: assert property (@(posedge clk) disable iff (!nrst)
        req.rd && req.addr == gpx_pkg::ADDR_P1_DATA |=> rdata[7:6] == $past(s1b_q[7:6]))
        else $error("bits 7:6 not digital");
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!nrst)
        ext_trig[0] |=> iflag_q[0])
        else $error("trigger lost");
    AST_IRQ: assert property (@(posedge clk) disable iff (!nrst)
        iflag_q[0] && ien_q[0] && ien_q[gpx_pkg::GIE_BIT] |=> irq)
        else $error("irq not raised");
    AST_FALL: assert property (@(posedge clk) disable iff (!nrst)
        p2_mode_q[1:0] == gpx_pkg::TRIG_FALL && ext_trig[0] |-> !ext_lvl[0])
        else $error("falling trigger at high level");
endmodule
`default_nettype wire

// File: rtl/gpx_pkg.sv
// Package with register map, field positions and types for the GPIO port block.
package gpx_pkg;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h06;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h07;
    localparam logic [7:0] ADDR_P1_DATA = 8'h20;
    localparam logic [7:0] ADDR_P1_DIR = 8'h21;
    localparam logic [7:0] ADDR_P1_PU = 8'h22;
    localparam logic [7:0] ADDR_P1_ANA = 8'h23;
    localparam logic [7:0] ADDR_P2_DATA = 8'h24;
    localparam logic [7:0] ADDR_P2_DIR = 8'h25;
    localparam logic [7:0] ADDR_P2_PU = 8'h26;
    localparam logic [7:0] ADDR_P2_MODE = 8'h27;
    localparam logic [7:0] ADDR_P3_DATA = 8'h28;
    localparam logic [7:0] ADDR_P3_DIR = 8'h29;
    localparam logic [7:0] ADDR_P3_PU = 8'h2a;
    localparam logic [7:0] ADDR_P3_MODE = 8'h2b;
    localparam logic [7:0] ADDR_P2_OD = 8'h37;
    // Reset values.
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_OD = 8'h18;
    // Writable bit masks for mixed-access registers.
    localparam logic [7:0] MASK_MODE = 8'h9f;
    localparam logic [7:0] MASK_OD = 8'h18;
    // Bits of port 1 that have an analog path.
    localparam logic [7:0] MASK_ANA = 8'h3f;
    // Interrupt enable register: global enable bit, ext enables at bits 0..3.
    localparam int GIE_BIT = 7;
    localparam logic [1:0] TRIG_FALL = 2'h0;
    localparam logic [1:0] TRIG_RISE = 2'h1;
    // Bus request from the core.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpx_req_t;
    // Pad control for one 8-bit port.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } gpx_pad_t;
endpackage

// File: rtl/gpx_edge.sv
// Synchroniser and trigger detector for one external interrupt line.
`timescale 1ns/1ps
`default_nettype none
module gpx_edge
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Pin and mode.
    input wire logic pin,
    input wire logic [1:0] mode,
    // Result.
    output logic level,
    output logic trig
);
    logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

    // Two flops clean the Schmitt-trigger pin; a third holds the previous level.
    always_comb
    begin
        s1_d = pin;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign level = s2_q;

    // Compare successive synchronised levels against the selected direction.
    always_comb
    begin
        if (mode == gpx_pkg::TRIG_FALL)
            trig = s3_q & ~s2_q;
        else if (mode == gpx_pkg::TRIG_RISE)
            trig = ~s3_q & s2_q;
        else
            trig = s3_q ^ s2_q;
    end
endmodule
`default_nettype wire

// File: sim/gpx_pins.sv
// Pin model: resolves pad drive, outside drive and pull-ups into pin levels.
`timescale 1ns/1ps
`default_nettype none
module gpx_pins
(
    // Clock.
    input wire logic clk,
    // Pad controls from the block.
    input wire gpx_pkg::gpx_pad_t [2:0] pad,
    // Outside drivers.
    input wire logic [2:0][7:0] ext_val,
    input wire logic [2:0][7:0] ext_en,
    // Resolved levels.
    output logic [2:0][7:0] pin
);
    // Starts high so that a line nobody has driven yet floats low, like the block's reset synchronisers.
    logic [2:0][7:0] last_q = '1;

    // A floating line shows the inverse of its last driven level, so a stale value never reads as a match.
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (pad[p].oe[b])
                    pin[p][b] = pad[p].out[b];
                else if (ext_en[p][b])
                    pin[p][b] = ext_val[p][b];
                else if (pad[p].pu[b])
                    pin[p][b] = 1'b1;
                else
                    pin[p][b] = ~last_q[p][b];
            end
        end
    end

    // Last driven level of every line; it is held while the line floats, so a floating line stays steady.
    always @(posedge clk)
    begin
        for (int p = 0; p < 3; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (pad[p].oe[b] || ext_en[p][b] || pad[p].pu[b])
                    last_q[p][b] <= pin[p][b];
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the GPIO port block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk;
    logic nrst;
    gpx_pkg::gpx_req_t req;
    logic [7:0] rdata;
    logic [7:0] analog_en;
    logic irq;
    logic [2:0][7:0] pin;
    logic [2:0][7:0] ext_val;
    logic [2:0][7:0] ext_en;
    gpx_pkg::gpx_pad_t [2:0] pad;
    int n_errors;
    int check_count;
    logic [7:0] b;
    logic [7:0] ra [12] = '{8'h06, 8'h07, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h29, 8'h2a, 8'h2b, 8'h37};
    logic [7:0] rm [12] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h9f, 8'hff, 8'hff, 8'h9f, 8'h18};
    logic [7:0] sa [3] = '{8'h00, 8'h0f, 8'hff};

    gpx_ports i_gpx_ports (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .p1_in(pin[0]), .p2_in(pin[1]),
        .p3_in(pin[2]), .p1_pad(pad[0]), .p2_pad(pad[1]), .p3_pad(pad[2]), .analog_en(analog_en), .irq(irq));
    gpx_pins i_gpx_pins (.clk(clk), .pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pin(pin));

    // Compares one byte; every mismatch is reported at once.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares out, enable and pull-up of one port.
    task automatic chk_pad(input int p, input logic [23:0] exp);
        chk8(pad[p].out, exp[23:16]);
        chk8(pad[p].oe, exp[15:8]);
        chk8(pad[p].pu, exp[7:0]);
    endtask

    // Lets n edges pass, then steps off the edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One access; the request is held until the edge that takes it.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        req = '{wr: w, rd: ~w, addr: a, wdata: d};
        cyc(1);
        req = '0;
    endtask

    // Reads a register; the data stands in the cycle after the taking edge.
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk8(rdata, exp);
    endtask

    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // 100 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A hang counts as a failure; the tests need well under ten microseconds.
    initial
    begin
        #50000;
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        nrst = 1'b0;
        req = '0;
        ext_val = '0;
        ext_en = '0;
        n_errors = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        // Reset values, then writable masks, then clearing; unmapped space reads zero.
        for (int i = 0; i < 12; i++)
            rchk(ra[i], (i == 11) ? 8'h18 : 8'h00);
        for (int i = 2; i < 12; i++)
        begin
            acc(1'b1, ra[i], 8'hff);
            rchk(ra[i], rm[i]);
        end
        cyc(2);
        chk8(analog_en, 8'h00);
        for (int i = 2; i < 12; i++)
        begin
            acc(1'b1, ra[i], 8'h00);
            rchk(ra[i], 8'h00);
        end
        cyc(2);
        chk8(analog_en, 8'h3f);
        acc(1'b1, 8'h30, 8'hff);
        rchk(8'h30, 8'h00);
        // Pad controls of each port, then a recheck that later writes left them alone.
        for (int p = 0; p < 3; p++)
        begin
            b = 8'h20 + 8'(4 * p);
            acc(1'b1, b, 8'h5a);
            acc(1'b1, b + 8'h01, 8'hf0);
            acc(1'b1, b + 8'h02, 8'h0f);
            cyc(2);
            chk_pad(p, 24'h5a_f00f);
        end
        for (int p = 0; p < 3; p++)
            chk_pad(p, 24'h5a_f00f);
        // Open drain on port 2 bits 4:3: a bit holding 1 is released.
        acc(1'b1, 8'h25, 8'hff);
        acc(1'b1, 8'h24, 8'h08);
        acc(1'b1, 8'h37, 8'h18);
        cyc(2);
        chk8(pad[1].oe, 8'hf7);
        acc(1'b1, 8'h37, 8'h00);
        cyc(2);
        chk8(pad[1].oe, 8'hff);
        // Port 1 inputs through the analog select gate.
        acc(1'b1, 8'h21, 8'h00);
        ext_en[0] = 8'hff;
        ext_val[0] = 8'he7;
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b1, 8'h23, sa[i]);
            cyc(4);
            rchk(8'h20, 8'he7 & (sa[i] | 8'hc0));
            chk8(analog_en, ~sa[i] & 8'h3f);
        end
        ext_en[0] = 8'h00;
        acc(1'b1, 8'h21, 8'hff);
        cyc(4);
        rchk(8'h20, 8'h5a);
        acc(1'b1, 8'h21, 8'h00);
        acc(1'b1, 8'h22, 8'hff);
        cyc(4);
        rchk(8'h20, 8'hff);
        // Port 2 pull-ups on the interrupt bits.
        acc(1'b1, 8'h25, 8'h00);
        acc(1'b1, 8'h26, 8'h03);
        cyc(4);
        acc(1'b0, 8'h24, 8'h00);
        chk8(rdata & 8'h03, 8'h03);
        // Every line in every trigger mode, both edges.
        ext_en[1] = 8'h03;
        ext_en[2] = 8'h03;
        for (int i = 0; i < 4; i++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                ext_val[1 + i / 2][i % 2] = 1'b1;
                acc(1'b1, (i < 2) ? 8'h27 : 8'h2b, 8'(m << (2 * (i % 2))));
                cyc(6);
                acc(1'b1, 8'h06, 8'h00);
                ext_val[1 + i / 2][i % 2] = 1'b0;
                cyc(6);
                rchk(8'h06, (m == 1) ? 8'h00 : 8'(1 << i));
                acc(1'b1, 8'h06, 8'h00);
                ext_val[1 + i / 2][i % 2] = 1'b1;
                cyc(6);
                rchk(8'h06, (m == 0) ? 8'h00 : 8'(1 << i));
            end
        end
        // Request needs both the line enable and the global enable.
        acc(1'b1, 8'h07, 8'h81);
        acc(1'b1, 8'h06, 8'h00);
        ext_val[1][0] = 1'b0;
        cyc(6);
        chk8({7'h00, irq}, 8'h01);
        acc(1'b1, 8'h07, 8'h01);
        cyc(2);
        chk8({7'h00, irq}, 8'h00);
        acc(1'b1, 8'h07, 8'h80);
        cyc(2);
        chk8({7'h00, irq}, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
